// *** shunt_amp_control_register.sv ***
// amplifier control register with blanking timer and gate drive window check
`default_nettype none
module shunt_amp_control_register #(
    parameter int unsigned GATE_DRIVE_CYCLES =
        (shunt_amp_pkg::GATE_DRIVE_NS * shunt_amp_pkg::CLK_MHZ) / 1000
) (
    input  wire logic                              sys_clk,
    input  wire logic                              reset_n,
    input  wire logic [shunt_amp_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic                              reg_write,
    input  wire logic                              reg_read,
    input  wire logic [shunt_amp_pkg::DATA_W-1:0]  reg_wdata,
    output logic      [shunt_amp_pkg::DATA_W-1:0]  reg_rdata,
    output logic                                   reg_rvalid,
    input  wire logic                              hb1_switch,
    input  wire logic                              hb2_switch,
    input  wire logic                              gate_settled,
    output logic                                   sample_hold_enable,
    output logic                                   blanking_trigger_select,
    output logic      [2:0]                        blanking_duration,
    output logic                                   reference_divider_select,
    output logic      [1:0]                        amplifier_gain_code,
    output logic                                   amp_output_blank,
    output logic                                   gate_fault,
    output logic      [3:0]                        hs_source_current,
    output logic      [3:0]                        hs_sink_current,
    output logic      [3:0]                        ls_source_current,
    output logic      [3:0]                        ls_sink_current
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  drive_hs;
        logic [7:0]  drive_ls;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        blank;
        logic [15:0] blank_cnt;
        logic        window;
        logic [15:0] drv_cnt;
        logic        fault;
    } state_s;

    localparam logic [15:0] DRV_CYC = 16'(GATE_DRIVE_CYCLES);

    state_s q;
    state_s d;

    // blanking length in eighths of the drive time
    function automatic logic [3:0] blank_eighths(input logic [2:0] code);
        case (code)
            3'h1:    blank_eighths = 4'h2;
            3'h2:    blank_eighths = 4'h3;
            3'h3:    blank_eighths = 4'h4;
            3'h4:    blank_eighths = 4'h5;
            3'h6:    blank_eighths = 4'h7;
            3'h7:    blank_eighths = 4'h8;
            default: blank_eighths = 4'h0; // off and reserved code alike
        endcase
    endfunction : blank_eighths

    logic        trigger;
    logic [19:0] blank_prod;
    logic [15:0] blank_len;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d          = q;
        d.rvalid   = 1'b0;
        trigger    = q.ctrl[shunt_amp_pkg::BLK_SEL_BIT] ? hb2_switch : hb1_switch;
        blank_prod = 20'(DRV_CYC) *
                     20'(blank_eighths(q.ctrl[shunt_amp_pkg::BLK_MSB:shunt_amp_pkg::BLK_LSB]));
        blank_len  = blank_prod[shunt_amp_pkg::EIGHTHS_SHIFT +: 16];

        // register writes, full byte stored so the reserved code reads back
        if (reg_write) begin
            case (reg_addr)
                shunt_amp_pkg::AMP_CTRL_ADDR: d.ctrl     = reg_wdata;
                shunt_amp_pkg::DRIVE_HS_ADDR: d.drive_hs = reg_wdata;
                shunt_amp_pkg::DRIVE_LS_ADDR: d.drive_ls = reg_wdata;
                default: ;
            endcase
        end
        if (reg_read) begin
            d.rvalid = 1'b1;
            case (reg_addr)
                shunt_amp_pkg::AMP_CTRL_ADDR: d.rdata = q.ctrl;
                shunt_amp_pkg::DRIVE_HS_ADDR: d.rdata = q.drive_hs;
                shunt_amp_pkg::DRIVE_LS_ADDR: d.rdata = q.drive_ls;
                default:                      d.rdata = 8'h00;
            endcase
        end

        // blanking timer, restarted by each switching edge of the chosen bridge
        if (trigger && blank_len != 16'h0000) begin
            d.blank     = 1'b1;
            d.blank_cnt = blank_len - 16'h0001;
        end else if (q.blank_cnt != 16'h0000) begin
            d.blank_cnt = q.blank_cnt - 16'h0001;
        end else begin
            d.blank     = 1'b0;
        end

        // drive window: any switching edge opens it; late settle is a fault
        if (hb1_switch || hb2_switch) begin
            d.window  = 1'b1;
            d.drv_cnt = DRV_CYC;
            d.fault   = 1'b0;
        end else if (q.window) begin
            if (gate_settled) begin
                d.window = 1'b0;
            end else if (q.drv_cnt == 16'h0001) begin
                d.window = 1'b0;
                d.fault  = 1'b1;
            end else begin
                d.drv_cnt = q.drv_cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q          <= '0;
            q.ctrl     <= shunt_amp_pkg::AMP_CTRL_RESET;
            q.drive_hs <= shunt_amp_pkg::DRIVE_RESET;
            q.drive_ls <= shunt_amp_pkg::DRIVE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fields leave straight from the register flops
    assign reg_rdata                = q.rdata;
    assign reg_rvalid               = q.rvalid;
    assign sample_hold_enable       = q.ctrl[shunt_amp_pkg::SH_EN_BIT];
    assign blanking_trigger_select  = q.ctrl[shunt_amp_pkg::BLK_SEL_BIT];
    assign blanking_duration        = q.ctrl[shunt_amp_pkg::BLK_MSB:shunt_amp_pkg::BLK_LSB];
    assign reference_divider_select = q.ctrl[shunt_amp_pkg::DIV_BIT];
    assign amplifier_gain_code      = q.ctrl[shunt_amp_pkg::GAIN_MSB:shunt_amp_pkg::GAIN_LSB];
    assign amp_output_blank         = q.blank;
    assign gate_fault               = q.fault;
    assign hs_source_current        = q.drive_hs[shunt_amp_pkg::SRC_MSB:shunt_amp_pkg::SRC_LSB];
    assign hs_sink_current          = q.drive_hs[shunt_amp_pkg::SNK_MSB:shunt_amp_pkg::SNK_LSB];
    assign ls_source_current        = q.drive_ls[shunt_amp_pkg::SRC_MSB:shunt_amp_pkg::SRC_LSB];
    assign ls_sink_current          = q.drive_ls[shunt_amp_pkg::SNK_MSB:shunt_amp_pkg::SNK_LSB];

endmodule : shunt_amp_control_register
`default_nettype wire

// *** shunt_amp_control_register_sva.sv ***
// assertion checker for the shunt amplifier control register
`default_nettype none
module shunt_amp_sva #(parameter int unsigned GATE_DRIVE_CYCLES = 8) (
    input wire logic       sys_clk, reset_n, reg_write, reg_read, reg_rvalid,
    input wire logic       hb1_switch, hb2_switch, gate_settled, amp_output_blank, gate_fault,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       sample_hold_enable, blanking_trigger_select, reference_divider_select,
    input wire logic [2:0] blanking_duration,
    input wire logic [1:0] amplifier_gain_code,
    input wire logic [3:0] hs_source_current, hs_sink_current
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic [7:0] ctrl = {sample_hold_enable, blanking_trigger_select, blanking_duration,
                             reference_divider_select, amplifier_gain_code};
    wire logic       trig = blanking_trigger_select ? hb2_switch : hb1_switch;
    wire logic       other = blanking_trigger_select ? hb1_switch : hb2_switch;
    wire logic       quiet = !gate_settled && !hb1_switch && !hb2_switch;
    rvalid_pulse_a: assert property (reg_read |=> reg_rvalid) else $error("no read answer");
    rvalid_quiet_a: assert property (!reg_read |=> !reg_rvalid) else $error("stray answer");
    ctrl_write_a: assert property (reg_write && reg_addr == 5'h0d |=> ctrl == $past(reg_wdata))
        else $error("control write lost");
    ctrl_hold_a: assert property (!(reg_write && reg_addr == 5'h0d) |=> $stable(ctrl))
        else $error("control changed unasked");
    blank_len_a: assert property (trig && blanking_duration == 3'h3 |=> amp_output_blank [*4])
        else $error("blanking too short");
    blank_none_a: assert property ((blanking_duration == 3'h0 || blanking_duration == 3'h5)
        && !amp_output_blank |=> !amp_output_blank) else $error("blanking while disabled");
    blank_other_a: assert property (other && !trig && !amp_output_blank |=> !amp_output_blank)
        else $error("wrong bridge blanked");
    fault_clear_a: assert property (hb1_switch || hb2_switch |=> !gate_fault)
        else $error("fault not cleared");
    fault_rise_a: assert property ((hb1_switch || hb2_switch) ##1 quiet [*8] |-> ##[0:1] gate_fault)
        else $error("fault not raised");
    drive_hs_a: assert property (reg_write && reg_addr == 5'h1e |=>
        {hs_source_current, hs_sink_current} == $past(reg_wdata)) else $error("drive lost");
endmodule : shunt_amp_sva
bind shunt_amp_control_register shunt_amp_sva #(.GATE_DRIVE_CYCLES(GATE_DRIVE_CYCLES)) sva (.*);
`default_nettype wire

// *** shunt_amp_host.sv ***
// host model driving the register port on the falling edge
`default_nettype none
module shunt_amp_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output var logic  [4:0] reg_addr = 5'h00,
    output var logic        reg_write = 1'b0,
    output var logic        reg_read = 1'b0,
    output var logic  [7:0] reg_wdata = 8'h00
);
    timeunit 1ns; timeprecision 1ps;
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        // released data inverted so a late capture shows up
        @(negedge sys_clk) {reg_wdata, reg_write} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge sys_clk) {reg_addr, reg_read} = {a, 1'b1};
        @(negedge sys_clk) reg_read = 1'b0;
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask : rd
endmodule : shunt_amp_host
`default_nettype wire

// *** shunt_amp_pkg.sv ***
// constants for the shunt amplifier control register block
`default_nettype none
package shunt_amp_pkg;
    localparam int unsigned ADDR_W          = 5;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned CNT_W           = 16;
    localparam logic [4:0]  AMP_CTRL_ADDR   = 5'h0d;
    localparam logic [4:0]  DRIVE_HS_ADDR   = 5'h1e;
    localparam logic [4:0]  DRIVE_LS_ADDR   = 5'h1f;
    localparam logic [7:0]  AMP_CTRL_RESET  = 8'h01;
    localparam logic [7:0]  DRIVE_RESET     = 8'h00;
    // field positions inside the amplifier control register
    localparam int unsigned SH_EN_BIT       = 7;
    localparam int unsigned BLK_SEL_BIT     = 6;
    localparam int unsigned BLK_MSB         = 5;
    localparam int unsigned BLK_LSB         = 3;
    localparam int unsigned DIV_BIT         = 2;
    localparam int unsigned GAIN_MSB        = 1;
    localparam int unsigned GAIN_LSB        = 0;
    // drive register layout: source current high nibble, sink low nibble
    localparam int unsigned SRC_MSB         = 7;
    localparam int unsigned SRC_LSB         = 4;
    localparam int unsigned SNK_MSB         = 3;
    localparam int unsigned SNK_LSB         = 0;
    // blanking codes, length given in eighths of the gate drive time
    localparam logic [2:0]  BLK_OFF         = 3'h0;
    localparam logic [2:0]  BLK_RESERVED    = 3'h5;
    localparam int unsigned EIGHTHS_SHIFT   = 3;
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned GATE_DRIVE_NS   = 4000;
endpackage : shunt_amp_pkg
`default_nettype wire

// *** test_shunt_amp_control_register.sv ***
// self-checking bench for the shunt amplifier control register
`default_nettype none
module test_shunt_amp_control_register;
    timeunit 1ns; timeprecision 1ps;
    logic sys_clk = 0, reset_n = 0, hb1_switch = 0, hb2_switch = 0, gate_settled = 0;
    logic [4:0] reg_addr;
    logic reg_write, reg_read, reg_rvalid, amp_output_blank, gate_fault;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic sample_hold_enable, blanking_trigger_select, reference_divider_select;
    logic [2:0] blanking_duration;
    logic [1:0] amplifier_gain_code;
    logic [3:0] hs_source_current, hs_sink_current, ls_source_current, ls_sink_current;
    int n_errors = 0, cmp_count = 0, cyc = 0, k;
    always #2 sys_clk = ~sys_clk;
    shunt_amp_control_register #(.GATE_DRIVE_CYCLES(8)) uut (.*);
    shunt_amp_host host (.*);
    wire logic [7:0] ctrl = {sample_hold_enable, blanking_trigger_select, blanking_duration,
                             reference_divider_select, amplifier_gain_code};
    task automatic check(input string what, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    always @(posedge sys_clk) if (++cyc == 5000) begin n_errors++; close_out(); end
    task automatic regs_test;
        logic [7:0] t [5] = '{8'h85, 8'h6a, 8'h28, 8'hff, 8'h00};
        host.rd(5'h0d, v); check("ctrl reset", v, 8'h01);
        foreach (t[i]) begin
            host.wr(5'h0d, t[i]); check("ctrl fields", ctrl, t[i]);
            host.rd(5'h0d, v); check("ctrl read", v, t[i]);
        end
        host.wr(5'h03, 8'h55); host.rd(5'h03, v); check("unmapped", v, 8'h00);
        check("ctrl kept", ctrl, 8'h00);
        host.wr(5'h1e, 8'ha5); host.wr(5'h1f, 8'h3c);
        check("hs drive", {hs_source_current, hs_sink_current}, 8'ha5);
        check("ls drive", {ls_source_current, ls_sink_current}, 8'h3c);
    endtask : regs_test
    task automatic pulse(input logic second, output int n);
        @(negedge sys_clk) {hb1_switch, hb2_switch} = {!second, second};
        @(negedge sys_clk) {hb1_switch, hb2_switch} = 2'b00;
        n = 0;
        repeat (12) begin n += amp_output_blank; @(negedge sys_clk); end
    endtask : pulse
    task automatic blank_test;
        // control value, bridge, expected blank cycles with an eight cycle drive time
        logic [15:0] b [10] = '{16'h1804, 16'h1810, 16'h5814, 16'h0802, 16'h3808,
                                16'h2800, 16'h0000, 16'h2005, 16'h3007, 16'h1003};
        foreach (b[i]) begin
            host.wr(5'h0d, b[i][15:8]); pulse(b[i][4], k);
            check("blank cycles", k[7:0], {4'h0, b[i][3:0]});
        end
    endtask : blank_test
    task automatic fault_test;
        gate_settled = 0; pulse(1'b0, k); check("fault set", {7'h00, gate_fault}, 8'h01);
        gate_settled = 1; pulse(1'b1, k); check("fault clear", {7'h00, gate_fault}, 8'h00);
    endtask : fault_test
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1;
        regs_test(); blank_test(); fault_test();
        close_out();
    end
endmodule : test_shunt_amp_control_register
`default_nettype wire
